// *** rtl/ptg_top.sv ***
`include "ptg_consts.svh"
`default_nettype none

// Operation
// - 85/8D enable, update cycle and count
// - Train or profile end raises event 19
// - 81/89 update cycle time only
// - 84/8C update pulse count only
// - Commit during a train waits for completion
// - A0/A8 select multi-segment profile from memory
// - First table byte gives segment count
// - Up to 255 segments accepted
// - Segment: cycle, signed delta, 32-bit count
// - Delta added to cycle after each pulse
module ptg_top #(
  parameter int unsigned MS_CYCLES = `PTG_MS_CYCLES
) (
  input wire logic clock_in,           // System clock, 100 MHz
  input wire logic rst_n_in,           // Synchronous reset, active low
  input wire logic psel_in,            // APB select
  input wire logic penable_in,         // APB enable
  input wire logic pwrite_in,          // APB direction, 1 is write
  input wire logic [13:0] paddr_in,    // APB byte address
  input wire logic [31:0] pwdata_in,   // APB write data
  output logic [31:0] prdata_out,      // APB read data
  output logic pready_out,             // APB ready
  output logic pslverr_out,            // APB error on unmapped address
  output logic pulse_output_pin_out,   // Pulse train output
  output logic irq_out                 // Level interrupt
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0] mem_ff [0:`PTG_MEM_BYTES-1];
  logic [7:0] pulse_control_byte_ff;
  logic [15:0] cycle_time_word_ff;
  logic [31:0] pulse_count_dword_ff;
  logic [15:0] profile_offset_word_ff;
  logic [15:0] com_ct_ff;
  logic [31:0] com_cnt_ff;
  logic [15:0] com_prof_ff;
  logic com_ms_ff;
  logic com_multi_ff;
  logic pend_ff;
  logic irq_stat_ff;
  logic irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic pulse_ff;
  logic irq_ff;
  ptg_pkg::ptg_state_t state_ff;
  ptg_pkg::ptg_state_t nxt_state;
  logic act_ms_ff;
  logic act_multi_ff;
  logic [15:0] act_ct_ff;
  logic [15:0] act_delta_ff;
  logic [31:0] act_rem_ff;
  logic [7:0] seg_left_ff;
  logic [`PTG_MEM_AW-1:0] rd_ptr_ff;
  logic [2:0] byte_idx_ff;
  logic [55:0] seg_buf_ff;
  logic [15:0] tcnt_ff;
  logic tick;
  logic access;
  logic setup_done;
  logic wr_en;
  logic mem_sel;
  logic mapped;
  logic commit;
  logic [`PTG_MEM_AW-1:0] mem_idx;
  logic [7:0] rd_byte;
  logic [15:0] period;
  logic pulse_end;
  logic train_end;
  logic start;
  logic [31:0] rd_val;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle, so the read
  // word is captured from settled registers and every mapped write lands at the
  // edge where the master sees pready.
  assign setup_done = psel_in && penable_in && !pready_ff;
  assign access = psel_in && penable_in && pready_ff;
  assign wr_en = access && pwrite_in && !pslverr_ff;
  assign mem_sel = paddr_in[13];
  assign mem_idx = paddr_in[12:2];
  assign commit = wr_en && !mem_sel && (paddr_in[11:0] == `PTG_OFF_COMMIT) && pwdata_in[0];

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (mem_sel) begin
      rd_val = {24'h00_0000, mem_ff[mem_idx]};
    end else begin
      case (paddr_in[11:0])
        `PTG_OFF_CTRL: rd_val = {24'h00_0000, pulse_control_byte_ff};
        `PTG_OFF_CYCLE: rd_val = {16'h0000, cycle_time_word_ff};
        `PTG_OFF_COUNT: rd_val = pulse_count_dword_ff;
        `PTG_OFF_PROFILE: rd_val = {16'h0000, profile_offset_word_ff};
        `PTG_OFF_COMMIT: rd_val = 32'h0000_0000;
        `PTG_OFF_STATUS: rd_val = {29'h0000_0000, pulse_ff, pend_ff, (state_ff != ptg_pkg::PTG_ST_IDLE)};
        `PTG_OFF_IRQ_STAT: rd_val = {31'h0000_0000, irq_stat_ff};
        `PTG_OFF_IRQ_MASK: rd_val = {31'h0000_0000, irq_mask_ff};
        default: mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_done;
      pslverr_ff <= setup_done && !mapped;
      prdata_ff <= (setup_done && !pwrite_in) ? rd_val : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Software registers and profile memory
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pulse_control_byte_ff <= `PTG_RST_CTRL;
      cycle_time_word_ff <= `PTG_RST_WORD;
      pulse_count_dword_ff <= `PTG_RST_DWORD;
      profile_offset_word_ff <= `PTG_RST_WORD;
      irq_mask_ff <= 1'b0;
    end else if (wr_en && !mem_sel) begin
      case (paddr_in[11:0])
        `PTG_OFF_CTRL: pulse_control_byte_ff <= pwdata_in[7:0];
        `PTG_OFF_CYCLE: cycle_time_word_ff <= pwdata_in[15:0];
        `PTG_OFF_COUNT: pulse_count_dword_ff <= pwdata_in;
        `PTG_OFF_PROFILE: profile_offset_word_ff <= pwdata_in[15:0];
        `PTG_OFF_IRQ_MASK: irq_mask_ff <= pwdata_in[0];
        default: irq_mask_ff <= irq_mask_ff;
      endcase
    end
  end

  // The table memory has no reset; software builds the profile before use.
  always_ff @(posedge clock_in) begin
    if (wr_en && mem_sel) begin
      mem_ff[mem_idx] <= pwdata_in[7:0];
    end
  end

  assign rd_byte = mem_ff[rd_ptr_ff];

  // ---------------------------------------------------------------------------
  // Commit: latch the parameters the next train will use
  // ---------------------------------------------------------------------------
  // Values land in a committed copy, never in the running engine, so a
  // commit mid-train cannot disturb the pulses already on the pin.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      com_ct_ff <= `PTG_RST_WORD;
      com_cnt_ff <= `PTG_RST_DWORD;
      com_prof_ff <= `PTG_RST_WORD;
      com_ms_ff <= 1'b0;
      com_multi_ff <= 1'b0;
    end else if (commit && pulse_control_byte_ff[`PTG_CTRL_EN]) begin
      com_ms_ff <= pulse_control_byte_ff[`PTG_CTRL_MS];
      com_multi_ff <= pulse_control_byte_ff[`PTG_CTRL_MULTI];
      com_prof_ff <= profile_offset_word_ff;
      if (pulse_control_byte_ff[`PTG_CTRL_UPD_CT]) begin
        com_ct_ff <= cycle_time_word_ff;
      end
      if (pulse_control_byte_ff[`PTG_CTRL_UPD_CNT]) begin
        com_cnt_ff <= pulse_count_dword_ff;
      end
    end
  end

  // A new commit in the start cycle wins over the clear.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pend_ff <= 1'b0;
    end else if (commit) begin
      pend_ff <= pulse_control_byte_ff[`PTG_CTRL_EN];
    end else if (start) begin
      pend_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Time base and pulse timing
  // ---------------------------------------------------------------------------
  ptg_timebase #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timebase (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .run_in(state_ff == ptg_pkg::PTG_ST_RUN),
    .ms_sel_in(act_ms_ff),
    .tick_out(tick)
  );

  // Periods below two units cannot show a high and a low half.
  assign period = (act_ct_ff < `PTG_MIN_PERIOD) ? `PTG_MIN_PERIOD : act_ct_ff;
  assign pulse_end = (state_ff == ptg_pkg::PTG_ST_RUN) && tick && (tcnt_ff == (period - 16'h0001));
  assign train_end = pulse_end && (act_rem_ff == 32'h0000_0001);
  assign start = (state_ff == ptg_pkg::PTG_ST_IDLE) && pend_ff;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || state_ff != ptg_pkg::PTG_ST_RUN) begin
      tcnt_ff <= 16'h0000;
    end else if (pulse_end) begin
      tcnt_ff <= 16'h0000;
    end else if (tick) begin
      tcnt_ff <= tcnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= (state_ff == ptg_pkg::PTG_ST_RUN) && (tcnt_ff < {1'b0, period[15:1]});
    end
  end

  // ---------------------------------------------------------------------------
  // Engine state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ptg_pkg::PTG_ST_IDLE: begin
        if (start && com_multi_ff) begin
          nxt_state = ptg_pkg::PTG_ST_HEAD;
        end else if (start) begin
          nxt_state = (com_cnt_ff == 32'h0000_0000) ? ptg_pkg::PTG_ST_DONE : ptg_pkg::PTG_ST_RUN;
        end
      end
      ptg_pkg::PTG_ST_HEAD: begin
        nxt_state = (rd_byte == 8'h00) ? ptg_pkg::PTG_ST_DONE : ptg_pkg::PTG_ST_FETCH;
      end
      ptg_pkg::PTG_ST_FETCH: begin
        if (byte_idx_ff == `PTG_SEG_BYTES) begin
          if ({seg_buf_ff[23:0], rd_byte} != 32'h0000_0000) begin
            nxt_state = ptg_pkg::PTG_ST_RUN;
          end else if (seg_left_ff == 8'h00) begin
            nxt_state = ptg_pkg::PTG_ST_DONE;
          end
        end
      end
      ptg_pkg::PTG_ST_RUN: begin
        if (train_end) begin
          nxt_state = (act_multi_ff && seg_left_ff != 8'h00) ? ptg_pkg::PTG_ST_FETCH : ptg_pkg::PTG_ST_DONE;
        end
      end
      ptg_pkg::PTG_ST_DONE: nxt_state = ptg_pkg::PTG_ST_IDLE;
      default: nxt_state = ptg_pkg::PTG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_ff <= ptg_pkg::PTG_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Profile walk and active train parameters
  // ---------------------------------------------------------------------------
  // Table words are big-endian: high byte at the lower address.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      act_ms_ff <= 1'b0;
      act_multi_ff <= 1'b0;
      act_ct_ff <= `PTG_RST_WORD;
      act_delta_ff <= `PTG_RST_WORD;
      act_rem_ff <= `PTG_RST_DWORD;
      seg_left_ff <= 8'h00;
      rd_ptr_ff <= '0;
      byte_idx_ff <= 3'h0;
      seg_buf_ff <= 56'h0;
    end else begin
      case (state_ff)
        ptg_pkg::PTG_ST_IDLE: begin
          if (start) begin
            act_ms_ff <= com_ms_ff;
            act_multi_ff <= com_multi_ff;
            act_ct_ff <= com_ct_ff;
            act_rem_ff <= com_cnt_ff;
            act_delta_ff <= 16'h0000;
            rd_ptr_ff <= com_prof_ff[`PTG_MEM_AW-1:0];
            byte_idx_ff <= 3'h0;
          end
        end
        ptg_pkg::PTG_ST_HEAD: begin
          seg_left_ff <= rd_byte;
          rd_ptr_ff <= rd_ptr_ff + 11'h001;
        end
        ptg_pkg::PTG_ST_FETCH: begin
          rd_ptr_ff <= rd_ptr_ff + 11'h001;
          byte_idx_ff <= byte_idx_ff + 3'h1;
          seg_buf_ff <= {seg_buf_ff[47:0], rd_byte};
          if (byte_idx_ff == `PTG_SEG_BYTES) begin
            act_ct_ff <= seg_buf_ff[55:40];
            act_delta_ff <= seg_buf_ff[39:24];
            act_rem_ff <= {seg_buf_ff[23:0], rd_byte};
            seg_left_ff <= seg_left_ff - 8'h01;
          end
        end
        ptg_pkg::PTG_ST_RUN: begin
          byte_idx_ff <= 3'h0;
          if (pulse_end) begin
            act_rem_ff <= act_rem_ff - 32'h0000_0001;
            act_ct_ff <= act_ct_ff + act_delta_ff;
          end
        end
        default: byte_idx_ff <= 3'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Completion event and interrupt
  // ---------------------------------------------------------------------------
  // Event set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_stat_ff <= 1'b0;
    end else if (state_ff == ptg_pkg::PTG_ST_DONE) begin
      irq_stat_ff <= 1'b1;
    end else if (wr_en && !mem_sel && paddr_in[11:0] == `PTG_OFF_IRQ_STAT && pwdata_in[0]) begin
      irq_stat_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irq_stat_ff && irq_mask_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign pulse_output_pin_out = pulse_ff;
  assign irq_out = irq_ff;

endmodule // ptg_top

`default_nettype wire

// *** rtl/ptg_consts.svh ***
`ifndef PTG_CONSTS_SVH
`define PTG_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets on the APB bus
// ---------------------------------------------------------------------------
`define PTG_OFF_CTRL      12'h000
`define PTG_OFF_CYCLE     12'h004
`define PTG_OFF_COUNT     12'h008
`define PTG_OFF_PROFILE   12'h00C
`define PTG_OFF_COMMIT    12'h010
`define PTG_OFF_STATUS    12'h014
`define PTG_OFF_IRQ_STAT  12'h018
`define PTG_OFF_IRQ_MASK  12'h01C
`define PTG_MEM_BASE      14'h2000

// ---------------------------------------------------------------------------
// Control byte fields and known values
// ---------------------------------------------------------------------------
`define PTG_CTRL_UPD_CT   0
`define PTG_CTRL_UPD_CNT  2
`define PTG_CTRL_MS       3
`define PTG_CTRL_MULTI    5
`define PTG_CTRL_EN       7
`define PTG_CTRL_BOTH_US  8'h85
`define PTG_CTRL_BOTH_MS  8'h8D
`define PTG_CTRL_CT_US    8'h81
`define PTG_CTRL_CT_MS    8'h89
`define PTG_CTRL_CNT_US   8'h84
`define PTG_CTRL_CNT_MS   8'h8C
`define PTG_CTRL_SEG_US   8'hA0
`define PTG_CTRL_SEG_MS   8'hA8

// ---------------------------------------------------------------------------
// Reset values, sizes and event numbers
// ---------------------------------------------------------------------------
`define PTG_RST_CTRL      8'h00
`define PTG_RST_WORD      16'h0000
`define PTG_RST_DWORD     32'h0000_0000
`define PTG_MEM_BYTES     2048
`define PTG_MEM_AW        11
`define PTG_MAX_SEGMENTS  8'hFF
`define PTG_SEG_BYTES     3'h7
`define PTG_DONE_EVENT    19
`define PTG_MIN_PERIOD    16'h0002

// ---------------------------------------------------------------------------
// Time base
// ---------------------------------------------------------------------------
`define PTG_CLK_NS        10
`define PTG_US_NS         1000
`define PTG_MS_NS         1000000
`define PTG_US_CYCLES     (`PTG_US_NS / `PTG_CLK_NS)
`define PTG_MS_CYCLES     (`PTG_MS_NS / `PTG_CLK_NS)

`endif

// *** rtl/ptg_pkg.sv ***
`default_nettype none

package ptg_pkg;

  typedef enum logic [2:0] {
    PTG_ST_IDLE,
    PTG_ST_HEAD,
    PTG_ST_FETCH,
    PTG_ST_RUN,
    PTG_ST_DONE
  } ptg_state_t;

endpackage : ptg_pkg

`default_nettype wire

// *** rtl/ptg_timebase.sv ***
`include "ptg_consts.svh"
`default_nettype none

module ptg_timebase #(
  parameter int unsigned MS_CYCLES = `PTG_MS_CYCLES
) (
  input wire logic clock_in,    // System clock
  input wire logic rst_n_in,    // Synchronous reset, active low
  input wire logic run_in,      // Counting allowed while high
  input wire logic ms_sel_in,   // 1 selects the millisecond base
  output logic tick_out         // One-cycle pulse per time base unit
);

  localparam int unsigned US_CYCLES = `PTG_US_CYCLES;

  logic [31:0] div_ff;
  logic [31:0] limit;

  assign limit = ms_sel_in ? (MS_CYCLES - 1) : (US_CYCLES - 1);

  // The divider restarts at one whenever the engine is out of RUN. The tick is
  // registered, so starting one step ahead makes the first unit of a train
  // as long as every later one instead of one clock longer.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !run_in) begin
      div_ff <= 32'h0000_0001;
      tick_out <= 1'b0;
    end else if (div_ff >= limit) begin
      div_ff <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

endmodule // ptg_timebase

`default_nettype wire

// *** tb/ptg_top_asserts.sv ***
`default_nettype none

module ptg_top_asserts #(
  parameter int unsigned MS_CYCLES = 20
) (
  input wire logic clock_in,             // System clock
  input wire logic rst_n_in,             // Synchronous reset, active low
  input wire logic psel_in,              // APB select
  input wire logic penable_in,           // APB enable
  input wire logic pwrite_in,            // APB direction
  input wire logic [13:0] paddr_in,      // APB byte address
  input wire logic [31:0] pwdata_in,     // APB write data
  input wire logic [31:0] prdata_out,    // APB read data
  input wire logic pready_out,           // APB ready
  input wire logic pslverr_out,          // APB error
  input wire logic pulse_output_pin_out, // Pulse train output
  input wire logic irq_out               // Level interrupt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // High time counter
  // ----------------------------------------
  logic [31:0] hi_ff;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !pulse_output_pin_out) begin
      hi_ff <= 32'h0000_0000;
    end else begin
      hi_ff <= hi_ff + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_setup;
    psel_in && !penable_in ##1 psel_in && penable_in;
  endsequence

  sequence s_mask_off;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == 14'h001C && !pwdata_in[0];
  endsequence

  a_ready_wait: assert property (s_setup |-> !pready_out ##1 pready_out)
    else $error("pready did not follow one wait state");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready stood longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero outside answer");
  a_unmapped_err: assert property (psel_in && penable_in && pready_out && !paddr_in[13]
    |-> pslverr_out == ((paddr_in[11:0] > 12'h01C) || (paddr_in[1:0] != 2'h0)))
    else $error("pslverr does not match address map");
  // A pulse lasts whole time base units, never a stray clock or two.
  a_high_units: assert property ($fell(pulse_output_pin_out) |-> hi_ff != 32'h0000_0000 &&
    ((hi_ff % 100) == 0 || (hi_ff % MS_CYCLES) == 0))
    else $error("pulse high time not whole units");
  a_irq_idle: assert property ($rose(irq_out) |-> !pulse_output_pin_out && !$past(pulse_output_pin_out))
    else $error("completion raised while pulsing");
  a_mask_off: assert property (s_mask_off |-> ##2 !irq_out)
    else $error("interrupt not masked");
endmodule // ptg_top_asserts

bind ptg_top ptg_top_asserts #(.MS_CYCLES(MS_CYCLES)) ptg_top_asserts_i (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .pulse_output_pin_out(pulse_output_pin_out),
  .irq_out(irq_out)
);

`default_nettype wire

// *** tb/ptg_step_load.sv ***
`default_nettype none

// A pulse-input load: counts steps and measures the last period and high time in clocks.
module ptg_step_load (
  input wire logic clock_in,        // System clock
  input wire logic rst_n_in,        // Synchronous reset, active low
  input wire logic step_in,         // Step input from the generator
  output logic [31:0] count_out,    // Steps seen
  output logic [31:0] period_out,   // Clocks between the last two rises
  output logic [31:0] high_out      // Clocks of the last high phase
);
  timeunit 1ns;
  timeprecision 1ps;

  logic step_ff;
  logic [31:0] since_ff;
  logic [31:0] hi_ff;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      step_ff <= 1'b0;
      since_ff <= 32'h0000_0000;
      hi_ff <= 32'h0000_0000;
      count_out <= 32'h0000_0000;
      period_out <= 32'h0000_0000;
      high_out <= 32'h0000_0000;
    end else begin
      step_ff <= step_in;
      since_ff <= since_ff + 32'h0000_0001;
      hi_ff <= hi_ff + 32'h0000_0001;
      if (step_in && !step_ff) begin
        count_out <= count_out + 32'h0000_0001;
        period_out <= since_ff;
        since_ff <= 32'h0000_0001;
        hi_ff <= 32'h0000_0001;
      end
      if (!step_in && step_ff) begin
        high_out <= hi_ff;
      end
    end
  end
endmodule // ptg_step_load

`default_nettype wire

// *** tb/ptg_top_tb.sv ***
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module ptg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned MS_CYC = 20;
  logic clock_in, rst_n_in, psel, penable, pwrite, pready, pslverr, pin, irq, rd_e;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, n_pulse, period, high_t, rd_v, base;
  int err_total, checked;
  logic mask_chk;

  ptg_top #(.MS_CYCLES(MS_CYC)) ptg_top_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pulse_output_pin_out(pin), .irq_out(irq));
  ptg_step_load ptg_step_load_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .step_in(pin),
    .count_out(n_pulse), .period_out(period), .high_out(high_t));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // Bus and completion helpers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [13:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd_v, e)
    `CHK(rd_e, ee)
  endtask

  // Waits for completion, checks the train seen by the load, then clears the event.
  task automatic wait_done(input logic [31:0] n_exp, input logic [31:0] p_exp, input logic [31:0] h_exp);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clock_in);
      n++;
    end
    `CHK(irq, 1'b1)
    `CHK(n_pulse - base, n_exp)
    `CHK(period, p_exp)
    `CHK(high_t, h_exp)
    // Taken before the clear: a queued train may already be pulsing by then.
    base = n_pulse;
    if (mask_chk) begin
      apb(1'b1, 14'h001C, 32'h0000_0000);
      repeat (2) @(posedge clock_in);
      `CHK(irq, 1'b0)
      rdc(14'h0018, 32'h0000_0001, 1'b0);
      apb(1'b1, 14'h001C, 32'h0000_0001);
    end
    apb(1'b1, 14'h0018, 32'h0000_0001);
    repeat (2) @(posedge clock_in);
    `CHK(irq, 1'b0)
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdc(14'h0000, 32'h0000_0000, 1'b0);
    rdc(14'h0004, 32'h0000_0000, 1'b0);
    rdc(14'h0008, 32'h0000_0000, 1'b0);
    apb(1'b1, 14'h001C, 32'h0000_0000);
    rdc(14'h001C, 32'h0000_0000, 1'b0);
    rdc(14'h0020, 32'h0000_0000, 1'b1);
    apb(1'b1, 14'h0000, 32'h0000_0005);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    rdc(14'h0014, 32'h0000_0000, 1'b0);
    rdc(14'h0018, 32'h0000_0000, 1'b0);
    apb(1'b1, 14'h0000, 32'h0000_0085);
    rdc(14'h0000, 32'h0000_0085, 1'b0);
    $display("t_regs done");
  endtask

  task automatic t_single;
    apb(1'b1, 14'h0004, 32'h0000_0003);
    apb(1'b1, 14'h0008, 32'h0000_0004);
    apb(1'b1, 14'h001C, 32'h0000_0001);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    mask_chk = 1'b1;
    wait_done(32'd4, 32'd300, 32'd100);
    mask_chk = 1'b0;
    $display("t_single done");
  endtask

  // Values written without their update bit must not reach the next train.
  task automatic t_update;
    apb(1'b1, 14'h0000, 32'h0000_0089);
    apb(1'b1, 14'h0004, 32'h0000_0004);
    apb(1'b1, 14'h0008, 32'h0000_0007);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    wait_done(32'd4, 32'd4 * MS_CYC, 32'd2 * MS_CYC);
    apb(1'b1, 14'h0000, 32'h0000_008C);
    apb(1'b1, 14'h0004, 32'h0000_0009);
    apb(1'b1, 14'h0008, 32'h0000_0002);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    wait_done(32'd2, 32'd4 * MS_CYC, 32'd2 * MS_CYC);
    $display("t_update done");
  endtask

  task automatic t_queue;
    apb(1'b1, 14'h0000, 32'h0000_008D);
    apb(1'b1, 14'h0004, 32'h0000_0002);
    apb(1'b1, 14'h0008, 32'h0000_0003);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    apb(1'b1, 14'h0000, 32'h0000_0081);
    apb(1'b1, 14'h0004, 32'h0000_0005);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    wait_done(32'd3, 32'd2 * MS_CYC, 32'd1 * MS_CYC);
    wait_done(32'd3, 32'd500, 32'd200);
    apb(1'b1, 14'h0000, 32'h0000_0084);
    apb(1'b1, 14'h0008, 32'h0000_0002);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    wait_done(32'd2, 32'd500, 32'd200);
    $display("t_queue done");
  endtask

  // Two segments: periods 2,4,6 then 6,4 units; the last pulse shows the negative delta.
  task automatic t_multi(input logic [7:0] ctl, input logic [31:0] unit);
    logic [7:0] tbl [17] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h03,
                             8'h00, 8'h06, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h02};
    for (int i = 0; i < 17; i++) begin
      apb(1'b1, 14'h2000 + 14'((16 + i) * 4), {24'h000000, tbl[i]});
    end
    apb(1'b1, 14'h0000, {24'h000000, ctl});
    apb(1'b1, 14'h000C, 32'h0000_0010);
    apb(1'b1, 14'h0010, 32'h0000_0001);
    wait_done(32'd5, 32'd6 * unit, 32'd2 * unit);
    $display("t_multi done");
  endtask

  initial begin
    repeat (60000) @(posedge clock_in);
    err_total++;
    report_and_stop();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    rst_n_in = 1'b0;
    base = 32'h0000_0000;
    err_total = 0;
    checked = 0;
    mask_chk = 1'b0;
    repeat (10) @(posedge clock_in);
    `CHK(pin, 1'b0)
    `CHK(irq, 1'b0)
    rst_n_in <= 1'b1;
    t_regs();
    t_single();
    t_update();
    t_queue();
    t_multi(8'hA8, MS_CYC);
    t_multi(8'hA0, 32'd100);
    report_and_stop();
  end
endmodule // ptg_top_tb

`default_nettype wire
